// *** asrp_pkg.sv ***
// Constants, types and decode functions for the converter serial port
package asrp_pkg;
	// Word widths
	localparam int CFG_W = 16;
	localparam int RES_W = 16;
	localparam int BIT_CNT_W = 4;
	localparam int IDLE_CNT_W = 21;
	// Configuration word layout and reset value
	localparam logic [CFG_W-1:0] CFG_RESET = 16'h058b;
	localparam int CFG_MUX_HI = 14;
	localparam int CFG_MUX_LO = 12;
	localparam int CFG_RSV4_BIT = 4;
	localparam int CFG_PULLUP_BIT = 3;
	localparam int CFG_WV_HI = 2;
	localparam int CFG_WV_LO = 1;
	localparam int CFG_RSV0_BIT = 0;
	localparam logic [1:0] WV_VALID = 2'h1;
	localparam logic [BIT_CNT_W-1:0] LAST_BIT = 4'hf;
	// Timing
	localparam int CLK_HZ = 40_000_000;
	localparam int TIMEOUT_MS = 28;
	localparam int TIMEOUT_CYC = (CLK_HZ / 1000) * TIMEOUT_MS;
	// Synchroniser lanes
	localparam int SY_SCLK = 0;
	localparam int SY_CS = 1;
	localparam int SY_DIN = 2;
	// Negative input choices
	localparam logic [1:0] NEG_ANALOG_INPUT_1 = 2'h0;
	localparam logic [1:0] NEG_ANALOG_INPUT_3 = 2'h1;
	localparam logic [1:0] NEG_GND = 2'h2;
	// Port states
	typedef enum logic [1:0] {
		ST_DESEL = 2'b00,
		ST_READY = 2'b01,
		ST_SHIFT = 2'b10
	} asrp_state_t;
	// Positive input index from the input pair select field
	function automatic logic [1:0] asrp_pos_sel(input logic [2:0] m);
		case (m)
			3'h2, 3'h5: asrp_pos_sel = 2'h1;
			3'h3, 3'h6: asrp_pos_sel = 2'h2;
			3'h7: asrp_pos_sel = 2'h3;
			default: asrp_pos_sel = 2'h0;
		endcase
	endfunction
	// Negative input choice from the input pair select field
	function automatic logic [1:0] asrp_neg_sel(input logic [2:0] m);
		case (m)
			3'h0: asrp_neg_sel = NEG_ANALOG_INPUT_1;
			3'h1, 3'h2, 3'h3: asrp_neg_sel = NEG_ANALOG_INPUT_3;
			default: asrp_neg_sel = NEG_GND;
		endcase
	endfunction
endpackage

// *** asrp_res_if.sv ***
// Carrier between the serial port and the result holder
`timescale 1ns/100ps
interface asrp_res_if;
	logic        new_flag;
	logic [15:0] snap_word;
	logic        take;
	logic        done;
	modport hold (input take, input done, output new_flag, output snap_word);
	modport port (output take, output done, input new_flag, input snap_word);
endinterface

// *** asrp_result_hold.sv ***
// Holds the latest conversion result, its new flag and a read snapshot
`timescale 1ns/100ps
module asrp_result_hold
	import asrp_pkg::*;
(
	// Clock and reset
	input  wire logic             clock,
	input  wire logic             reset_n,
	// Converter core
	input  wire logic             conv_valid,
	input  wire logic [RES_W-1:0] conv_data,
	// Serial port side
	asrp_res_if.hold              res
);
	logic [RES_W-1:0] latest_q, latest_d;
	logic [RES_W-1:0] snap_q, snap_d;
	logic             new_q, new_d;
	logic             arrived_q, arrived_d;

	// Next values; the snapshot only moves on take, so a completing
	// conversion never disturbs a word being shifted out
	always_comb begin
		latest_d = conv_valid ? conv_data : latest_q;
		// A result landing after the snapshot froze was not shifted out
		arrived_d = conv_valid ? 1'b1 : (res.take ? 1'b0 : arrived_q);
		// clear after read
		// Set wins over the clear; a late result keeps the flag up
		new_d = conv_valid ? 1'b1 : ((res.done && !arrived_q) ? 1'b0 : new_q);
		// stable read snapshot
		// Takes the incoming word so flag and snapshot move together
		snap_d = res.take ? latest_d : snap_q;
	end

	// Registers
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			latest_q <= 16'h0000;
			snap_q   <= 16'h0000;
			new_q    <= 1'b0;
			arrived_q <= 1'b0;
		end else begin
			latest_q <= latest_d;
			snap_q   <= snap_d;
			new_q    <= new_d;
			arrived_q <= arrived_d;
		end
	end

	assign res.new_flag  = new_q;
	assign res.snap_word = snap_q;

	AST_NEW_CLEAR: assert property (@(posedge clock) disable iff (!reset_n)
		res.done && !conv_valid && !arrived_q |=> !res.new_flag)
		else $error("new flag survived a completed read");
endmodule

// *** asrp_serial_port.sv ***
// Serial slave port with combined data out and ready line
//
// Behaviour
// - Mode one: clock rests low, phase one
// - Drive on rising, sample on falling edge
// - Abort transfer after long clock-low gap
// - Default: weak pull-up while deselected
// - Pull-up bit zero: release line
// - No ready pulse while deselected
// - On select, drive ready level immediately
// - Without new result, repeat last result
// - Reads never corrupted by new conversions
// - Four ground-referenced measurements selectable
// - Inputs zero to two against input three
// - Input pair select code mapping
// - Pull-up bit three, resets enabled
// - Config updates only with valid code
`timescale 1ns/100ps
module asrp_serial_port
	import asrp_pkg::*;
#(
	parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
	// Clock and reset
	input  wire logic             clock,
	input  wire logic             reset_n,
	// Serial pins
	input  wire logic             serial_clock,
	input  wire logic             chip_select_n,
	input  wire logic             data_in,
	output logic                  data_out_ready_line,
	output logic                  data_out_ready_line_oe_n,
	output logic                  data_out_ready_pullup_en,
	// Converter core
	input  wire logic             conv_valid,
	input  wire logic [RES_W-1:0] conv_data,
	// Configuration towards the converter
	output logic [CFG_W-1:0]      cfg_word,
	output logic [2:0]            input_pair_select,
	output logic [1:0]            pos_input_sel,
	output logic [1:0]            neg_input_sel,
	output logic                  transfer_abort
);
	import asrp_pkg::*;

	asrp_res_if res_if ();

	logic [2:0]            sy1_q, sy2_q, sy3_q;
	asrp_state_t           state_q, state_d;
	logic [BIT_CNT_W-1:0]  bit_cnt_q, bit_cnt_d;
	logic [IDLE_CNT_W-1:0] idle_cnt_q, idle_cnt_d;
	logic [RES_W-1:0]      tx_q, tx_d;
	logic [CFG_W-1:0]      rx_q, rx_d;
	logic [CFG_W-1:0]      cfg_q, cfg_d;
	logic [1:0]            pos_q, pos_d, neg_q, neg_d;
	logic                  dout_q, dout_d, oe_n_q, oe_n_d, pull_q, pull_d;
	logic                  take_q, take_d, done_q, done_d, abort_q, abort_d;
	logic                  sclk_rise, sclk_fall, cs_hi, din_s, ready_lvl;
	logic [CFG_W-1:0]      rx_next;

	asrp_result_hold u_hold (
		.clock      (clock),
		.reset_n    (reset_n),
		.conv_valid (conv_valid),
		.conv_data  (conv_data),
		.res        (res_if.hold)
	);

	// Pin synchronisers; the first stage feeds only the second
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			sy1_q <= 3'h2;
			sy2_q <= 3'h2;
			sy3_q <= 3'h2;
		end else begin
			sy1_q <= {data_in, chip_select_n, serial_clock};
			sy2_q <= sy1_q;
			sy3_q <= sy2_q;
		end
	end

	// idle-low clock, edges from synchronised samples
	assign sclk_rise = sy2_q[SY_SCLK] & ~sy3_q[SY_SCLK];
	assign sclk_fall = ~sy2_q[SY_SCLK] & sy3_q[SY_SCLK];
	assign cs_hi     = sy2_q[SY_CS];
	assign din_s     = sy2_q[SY_DIN];
	// Low while a fresh result waits; done_q masks the flag being cleared
	assign ready_lvl = ~res_if.new_flag | done_q;
	assign rx_next   = {rx_q[CFG_W-2:0], din_s};

	// Next-state logic for the whole port
	always_comb begin
		state_d    = state_q;
		bit_cnt_d  = bit_cnt_q;
		idle_cnt_d = idle_cnt_q;
		tx_d       = tx_q;
		rx_d       = rx_q;
		cfg_d      = cfg_q;
		dout_d     = dout_q;
		oe_n_d     = oe_n_q;
		pull_d     = pull_q;
		take_d     = 1'b0;
		done_d     = 1'b0;
		abort_d    = 1'b0;
		case (state_q)
			ST_DESEL: begin
				oe_n_d = 1'b1;
				pull_d = cfg_q[CFG_PULLUP_BIT];
				dout_d = 1'b1;
				if (!cs_hi) begin
					state_d   = ST_READY;
					oe_n_d    = 1'b0;
					pull_d    = 1'b0;
					dout_d    = ready_lvl;
					take_d    = 1'b1;
					bit_cnt_d = 4'h0;
				end
			end
			ST_READY: begin
				// Ready pulse may appear while selected and idle
				dout_d = ready_lvl;
				// snapshot repeats last result if nothing new
				take_d = 1'b1;
				if (sclk_rise) begin
					dout_d     = res_if.snap_word[RES_W-1];
					tx_d       = {res_if.snap_word[RES_W-2:0], 1'b0};
					// Freeze the snapshot from the first rising edge
					take_d     = 1'b0;
					idle_cnt_d = '0;
					state_d    = ST_SHIFT;
				end
			end
			ST_SHIFT: begin
				if (sy2_q[SY_SCLK]) begin
					idle_cnt_d = '0;
				end else begin
					idle_cnt_d = idle_cnt_q + 21'h000001;
				end
				if (sclk_rise) begin
					dout_d = tx_q[RES_W-1];
					tx_d   = {tx_q[RES_W-2:0], 1'b0};
				end
				if (sclk_fall) begin
					// sample data in on falling edge
					rx_d      = rx_next;
					bit_cnt_d = bit_cnt_q + 4'h1;
					if (bit_cnt_q == LAST_BIT) begin
						state_d   = ST_READY;
						bit_cnt_d = 4'h0;
						done_d    = 1'b1;
						dout_d    = 1'b1;
						if (rx_next[CFG_WV_HI:CFG_WV_LO] == WV_VALID) begin
							cfg_d = rx_next;
							// Reserved bits ignore writes
							cfg_d[CFG_RSV0_BIT] = cfg_q[CFG_RSV0_BIT];
							cfg_d[CFG_RSV4_BIT] = cfg_q[CFG_RSV4_BIT];
						end
					end
				end else if (!sy2_q[SY_SCLK] &&
				             idle_cnt_q == IDLE_CNT_W'(TIMEOUT_CYCLES - 1)) begin
					state_d    = ST_READY;
					bit_cnt_d  = 4'h0;
					idle_cnt_d = '0;
					abort_d    = 1'b1;
					dout_d     = ready_lvl;
				end
			end
			default: begin
				state_d = ST_DESEL;
			end
		endcase
		if (cs_hi && state_q != ST_DESEL) begin
			state_d   = ST_DESEL;
			oe_n_d    = 1'b1;
			pull_d    = cfg_q[CFG_PULLUP_BIT];
			dout_d    = 1'b1;
			bit_cnt_d = 4'h0;
		end
		pos_d = asrp_pos_sel(cfg_d[CFG_MUX_HI:CFG_MUX_LO]);
		neg_d = asrp_neg_sel(cfg_d[CFG_MUX_HI:CFG_MUX_LO]);
	end

	// Registers; pull-up enabled from reset, line released
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state_q    <= ST_DESEL;
			bit_cnt_q  <= 4'h0;
			idle_cnt_q <= '0;
			tx_q       <= 16'h0000;
			rx_q       <= 16'h0000;
			cfg_q      <= CFG_RESET;
			pos_q      <= 2'h0;
			neg_q      <= NEG_ANALOG_INPUT_1;
			dout_q     <= 1'b1;
			oe_n_q     <= 1'b1;
			pull_q     <= 1'b1;
			take_q     <= 1'b0;
			done_q     <= 1'b0;
			abort_q    <= 1'b0;
		end else begin
			state_q    <= state_d;
			bit_cnt_q  <= bit_cnt_d;
			idle_cnt_q <= idle_cnt_d;
			tx_q       <= tx_d;
			rx_q       <= rx_d;
			cfg_q      <= cfg_d;
			pos_q      <= pos_d;
			neg_q      <= neg_d;
			dout_q     <= dout_d;
			oe_n_q     <= oe_n_d;
			pull_q     <= pull_d;
			take_q     <= take_d;
			done_q     <= done_d;
			abort_q    <= abort_d;
		end
	end

	assign res_if.take = take_q;
	assign res_if.done = done_q;

	// Outputs straight from flops
	assign data_out_ready_line      = dout_q;
	assign data_out_ready_line_oe_n = oe_n_q;
	assign data_out_ready_pullup_en = pull_q;
	assign cfg_word                 = cfg_q;
	assign input_pair_select        = cfg_q[CFG_MUX_HI:CFG_MUX_LO];
	assign pos_input_sel            = pos_q;
	assign neg_input_sel            = neg_q;
	assign transfer_abort           = abort_q;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	AST_DESEL_QUIET: assert property (
		$past(cs_hi) |-> data_out_ready_line_oe_n)
		else $error("line driven while deselected");
	AST_PULL_FOLLOWS: assert property (
		$past(cs_hi) |-> data_out_ready_pullup_en == $past(cfg_q[CFG_PULLUP_BIT]))
		else $error("pull-up does not follow its enable bit");
	AST_TRISTATE: assert property (
		$past(cs_hi) && !$past(cfg_q[CFG_PULLUP_BIT])
		|-> data_out_ready_line_oe_n && !data_out_ready_pullup_en)
		else $error("line not floating with pull-up off");
	AST_READY_LEVEL: assert property (
		$fell(cs_hi) |=> !data_out_ready_line_oe_n &&
		data_out_ready_line == !$past(res_if.new_flag))
		else $error("wrong ready level at selection");
	AST_FIRST_BIT: assert property (
		state_q == ST_READY && sclk_rise && !cs_hi
		|=> data_out_ready_line == $past(res_if.snap_word[RES_W-1]) ##0 state_q == ST_SHIFT)
		else $error("first bit not from snapshot");
	AST_RISE_ONLY: assert property (
		state_q == ST_SHIFT && $past(state_q) == ST_SHIFT && $changed(dout_q)
		|-> $past(sclk_rise))
		else $error("data changed off a rising edge");
	AST_TX_STABLE: assert property (
		state_q == ST_SHIFT && !sclk_rise |=> $stable(tx_q))
		else $error("shift word disturbed mid read");
	AST_TIMEOUT: assert property (
		state_q == ST_SHIFT && !cs_hi && !sy2_q[SY_SCLK] && !sclk_fall &&
		idle_cnt_q == IDLE_CNT_W'(TIMEOUT_CYCLES - 1)
		|=> transfer_abort && state_q == ST_READY && bit_cnt_q == 4'h0)
		else $error("timeout did not abandon transfer");
	AST_CFG_GUARD: assert property (
		$changed(cfg_q) |-> $past(done_d) && cfg_q[CFG_WV_HI:CFG_WV_LO] == WV_VALID)
		else $error("config changed without valid code");
	AST_MUX_GND: assert property (
		cfg_q[CFG_MUX_HI] |-> neg_input_sel == NEG_GND &&
		pos_input_sel == cfg_q[CFG_MUX_LO+1:CFG_MUX_LO])
		else $error("ground-referenced mapping wrong");
	AST_MUX_COMMON: assert property (
		!cfg_q[CFG_MUX_HI] && cfg_q[CFG_MUX_LO+1:CFG_MUX_LO] != 2'h0
		|-> neg_input_sel == NEG_ANALOG_INPUT_3)
		else $error("common point mapping wrong");
endmodule

// *** asrp_host_model.sv ***
// Bit-bang bus master model that drives the converter serial pins
`timescale 1ns/100ps
module asrp_host_model #(
	parameter int HALF_CYC = 8
) (
	// System clock used only to pace the pins
	input  wire logic clock,
	// Serial pins
	output logic      serial_clock,
	output logic      chip_select_n,
	output logic      data_in,
	input  wire logic line_in
);
	initial begin
		serial_clock = 1'b0;
		chip_select_n = 1'b1;
		data_in = 1'b0;
	end
	task automatic sel(input logic lvl);
		@(negedge clock);
		chip_select_n = lvl;
		// Leave the synchroniser and ready level time to settle
		repeat (6) @(negedge clock);
	endtask
	task automatic xfer(input logic [15:0] w, input int nbits, output logic [15:0] r);
		r = 16'h0000;
		for (int i = 0; i < nbits; i++) begin
			@(negedge clock);
			serial_clock = 1'b1;
			data_in = w[15-i];
			repeat (HALF_CYC) @(negedge clock);
			r[15-i] = line_in;
			serial_clock = 1'b0;
			repeat (HALF_CYC) @(negedge clock);
		end
	endtask
endmodule

// *** adc_serial_port_ready_signalling_tb_top.sv ***
// Self-checking bench for the converter serial port
`timescale 1ns/100ps
module adc_serial_port_ready_signalling_tb_top;
	import asrp_pkg::*;
	localparam int TO_CYC = 200;
	// Clock, reset and converter side
	logic             clock;
	logic             reset_n;
	logic             conv_valid;
	logic [RES_W-1:0] conv_data;
	// Serial pins
	logic             serial_clock;
	logic             chip_select_n;
	logic             data_in;
	logic             line;
	logic             oe_n;
	logic             pullup_en;
	logic             line_pin;
	logic             float_q = 1'b0;
	// Configuration outputs
	logic [CFG_W-1:0] cfg_word;
	logic [2:0]       input_pair_select;
	logic [1:0]       pos_input_sel;
	logic [1:0]       neg_input_sel;
	logic             transfer_abort;
	int               error_cnt;
	int               num_checks;
	logic [15:0]      r;

	asrp_serial_port #(
		.TIMEOUT_CYCLES(TO_CYC)
	) u_dut (
		.clock                    (clock),
		.reset_n                  (reset_n),
		.serial_clock             (serial_clock),
		.chip_select_n            (chip_select_n),
		.data_in                  (data_in),
		.data_out_ready_line      (line),
		.data_out_ready_line_oe_n (oe_n),
		.data_out_ready_pullup_en (pullup_en),
		.conv_valid               (conv_valid),
		.conv_data                (conv_data),
		.cfg_word                 (cfg_word),
		.input_pair_select        (input_pair_select),
		.pos_input_sel            (pos_input_sel),
		.neg_input_sel            (neg_input_sel),
		.transfer_abort           (transfer_abort)
	);
	asrp_host_model u_host (
		.clock         (clock),
		.serial_clock  (serial_clock),
		.chip_select_n (chip_select_n),
		.data_in       (data_in),
		.line_in       (line_pin)
	);

	// Undriven line without pull-up toggles so a stale value never reads as valid
	always @(posedge clock) float_q <= ~float_q;
	assign line_pin = (oe_n === 1'b0) ? line : ((pullup_en === 1'b1) ? 1'b1 : float_q);

	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	task automatic report_and_stop();
		if (error_cnt == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic conv(input logic [15:0] d);
		@(negedge clock);
		conv_valid = 1'b1;
		conv_data = d;
		@(negedge clock);
		conv_valid = 1'b0;
	endtask
	task automatic sc_reset();
		chk(cfg_word, CFG_RESET);
		chk(pullup_en, 1'b1);
		chk(oe_n, 1'b1);
		chk(transfer_abort, 1'b0);
	endtask
	task automatic sc_ready();
		conv(16'ha5c3);
		repeat (8) @(negedge clock);
		chk(oe_n, 1'b1);
		u_host.sel(1'b0);
		chk({oe_n, line}, 2'h0);
		u_host.xfer(16'h0000, 16, r);
		chk(r, 16'ha5c3);
		chk(line, 1'b1);
		chk(cfg_word, CFG_RESET);
		fork
			u_host.xfer(16'h0000, 16, r);
			begin
				repeat (60) @(negedge clock);
				conv(16'h3c5a);
			end
		join
		chk(r, 16'ha5c3);
		chk(line, 1'b0);
		u_host.xfer(16'h0000, 16, r);
		chk(r, 16'h3c5a);
		u_host.sel(1'b1);
	endtask
	task automatic sc_cfg();
		logic [15:0] w;
		logic [15:0] keep;
		u_host.sel(1'b0);
		for (int m = 0; m < 8; m++) begin
			w = {1'b0, m[2:0], 12'h59a};
			u_host.xfer(w, 16, r);
			chk(cfg_word, (w & 16'hffef) | 16'h0001);
			chk(input_pair_select, m[2:0]);
			chk(pos_input_sel, (m == 0) ? 2'h0 : (m < 4) ? m[1:0] - 2'h1 : m[1:0]);
			chk(neg_input_sel, (m == 0) ? NEG_ANALOG_INPUT_1 : (m < 4) ? NEG_ANALOG_INPUT_3 : NEG_GND);
		end
		keep = cfg_word;
		for (int c = 0; c < 4; c++) begin
			if (c != 1) begin
				u_host.xfer({1'b0, 3'h5, 12'h598} | 16'(c << 1), 16, r);
				chk(cfg_word, keep);
			end
		end
		u_host.sel(1'b1);
	endtask
	task automatic sc_pullup();
		u_host.sel(1'b0);
		u_host.xfer({1'b0, 3'h4, 12'h592}, 16, r);
		u_host.sel(1'b1);
		chk({oe_n, pullup_en}, 2'h2);
		u_host.sel(1'b0);
		u_host.xfer({1'b0, 3'h4, 12'h59a}, 16, r);
		u_host.sel(1'b1);
		chk({oe_n, pullup_en, line_pin}, 3'h7);
	endtask
	task automatic sc_timeout();
		logic        seen;
		logic [15:0] keep;
		seen = 1'b0;
		keep = cfg_word;
		conv(16'h1234);
		u_host.sel(1'b0);
		u_host.xfer(16'hffff, 5, r);
		for (int i = 0; i < TO_CYC + 100 && !seen; i++) begin
			@(negedge clock);
			seen = (transfer_abort === 1'b1);
		end
		chk(seen, 1'b1);
		if (!seen)
			report_and_stop();
		repeat (4) @(negedge clock);
		chk(line, 1'b0);
		chk(cfg_word, keep);
		u_host.xfer(16'h0000, 16, r);
		chk(r, 16'h1234);
		u_host.sel(1'b1);
	endtask

	// Watchdog so that a stuck handshake still ends in a verdict
	initial begin
		repeat (100000) @(posedge clock);
		error_cnt++;
		$display("[FAIL] %0t ns: run did not finish", $time);
		report_and_stop();
	end
	// Main sequence
	initial begin
		error_cnt = 0;
		num_checks = 0;
		reset_n = 1'b0;
		conv_valid = 1'b0;
		conv_data = 16'h0000;
		repeat (12) @(negedge clock);
		reset_n = 1'b1;
		repeat (4) @(negedge clock);
		sc_reset();
		sc_ready();
		sc_cfg();
		sc_pullup();
		sc_timeout();
		report_and_stop();
	end
endmodule
